// file: hdl/cslk_map.svh
// register map, field positions and frame layout of the startup control block
`ifndef CSLK_MAP_SVH
`define CSLK_MAP_SVH
// register byte offsets
`define CSLK_REG_RXC    8'h00
`define CSLK_REG_TXC    8'h04
`define CSLK_REG_OVR    8'h08
`define CSLK_REG_ING    8'h0C
`define CSLK_REG_IST    8'h10
`define CSLK_REG_ICLR   8'h14
`define CSLK_REG_IEN    8'h18
`define CSLK_REG_MODE   8'h1C
// receive control bits
`define CSLK_RXC_DATA   0
`define CSLK_RXC_FLOW   1
// transmit control bits
`define CSLK_TXC_IDLE   0
`define CSLK_TXC_EN     1
`define CSLK_TXC_CC     2
`define CSLK_TXC_CD     3
// ready status override fields
`define CSLK_OVR_EGR    0
`define CSLK_OVR_ING    1
`define CSLK_OVR_RDY    7:6
`define CSLK_OVR_MASK   8'hC3
`define CSLK_OVR_RST    8'h03
// interrupt bits
`define CSLK_INT_DIDLE  0
`define CSLK_INT_FIDLE  1
// mode bits
`define CSLK_MODE_EGR   0
`define CSLK_MODE_SPX   1
// frame header: type, ready bits {control, data}, msb first on the wire
`define CSLK_HDR_TYPE   7:6
`define CSLK_HDR_RDY    5:4
`define CSLK_LAST_BIT   3'h7
`define CSLK_T_IDLE     2'h0
`define CSLK_T_CTRL     2'h1
`define CSLK_T_DATA     2'h2
`define CSLK_RDY_HIGH   2'h3
`define CSLK_HDR_PAD    4'h0
// pin pair layout: [1] start of frame, [0] serial bit
`define CSLK_PIN_SOF    1
`define CSLK_PIN_DAT    0
`endif

// file: hdl/cslk_pkg.sv
// types shared by the startup control block
package cslk_pkg;
    typedef enum logic {CSLK_TX_WAIT, CSLK_TX_SHIFT} cslk_txst_t;
    typedef logic [7:0] cslk_hdr_t;
endpackage

// file: hdl/cslk_rx_det.sv
// frame header receiver for one serial link path
`timescale 1ns/10ps
`include "cslk_map.svh"
module cslk_rx_det
    import cslk_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       link_edge,
    input  wire logic       enable,
    input  wire logic       sof,
    input  wire logic       dat,
    output logic            hdr_valid,
    output cslk_hdr_t       hdr
);
    logic [2:0] cnt_ff;
    logic       in_frame_ff;

    // shift header bits in on each link edge; a frame starts with sof
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            hdr         <= 8'h00;
            cnt_ff      <= 3'h0;
            in_frame_ff <= 1'b0;
            hdr_valid   <= 1'b0;
        end
        else
        begin
            hdr_valid <= 1'b0;
            if (!enable)
            begin
                in_frame_ff <= 1'b0;  // frames seen while off are dropped
                cnt_ff      <= 3'h0;
            end
            else if (link_edge && (in_frame_ff || sof))
            begin
                hdr         <= {hdr[6:0], dat};
                cnt_ff      <= cnt_ff + 3'h1;
                in_frame_ff <= (cnt_ff != `CSLK_LAST_BIT);
                hdr_valid   <= (cnt_ff == `CSLK_LAST_BIT);
            end
        end
    end
endmodule

// file: hdl/cslk_startup.sv
// cell link startup control: ready override, idle detection, tx/rx enables
//
// Functional notes
// - ingress resets with egress override forcing ready low
// - egress resets with ingress override forcing ready bits
// - idle frames accepted only after receive enable
// - first data idle sets flag and interrupt
// - first flow idle sets own flag, interrupt
// - override bits 7:6 give forced ready values
// - clearing egress override sends own idle state
// - idle plus enable sends idle frames, ready low
// - without ingress override, ready follows sideband input
// - sideband ready low until idle detected, then high
// - sideband ready bits go into sent headers
// - ingress status shows received manager ready bits
// - normal frames only with both frame enables
// - simplex ingress flow output sends ready high
// - simplex runs data and flow paths independently
//
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/10ps
`include "cslk_map.svh"
module cslk_startup
    import cslk_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic             pslverr,
    output logic [31:0]      prdata,
    output logic             irq,
    input  wire logic        link_clk,
    input  wire logic [1:0]  rx_data_pins,
    input  wire logic [1:0]  rx_flow_pins,
    input  wire logic [1:0]  ready_sideband_in,
    output logic [1:0]       tx_data_pins,
    output logic [1:0]       tx_flow_pins,
    output logic [1:0]       ready_sideband_out
);
    //------------------------------------------------------------
    // pin synchronisers
    //------------------------------------------------------------
    localparam int NPIN = 7;
    logic [NPIN-1:0] raw;
    logic [NPIN-1:0] s1_ff;
    logic [NPIN-1:0] s2_ff;
    logic [NPIN-1:0] s3_ff;
    logic [NPIN-1:0] st_ff;
    logic            lk_prev_ff;
    logic            link_edge;

    assign raw = {link_clk, rx_data_pins, rx_flow_pins, ready_sideband_in};

    // three stages; a level counts once stages two and three agree
    generate
        for (genvar i = 0; i < NPIN; i++)
        begin : g_sync
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    s1_ff[i] <= 1'b0;
                    s2_ff[i] <= 1'b0;
                    s3_ff[i] <= 1'b0;
                    st_ff[i] <= 1'b0;
                end
                else
                begin
                    s1_ff[i] <= raw[i];
                    s2_ff[i] <= s1_ff[i];
                    s3_ff[i] <= s2_ff[i];
                    if (s2_ff[i] == s3_ff[i])
                        st_ff[i] <= s3_ff[i];
                end
            end
        end
    endgenerate

    // link clock rising edge found in the pclk domain
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            lk_prev_ff <= 1'b0;
        else
            lk_prev_ff <= st_ff[6];
    end

    assign link_edge = st_ff[6] & ~lk_prev_ff;

    //------------------------------------------------------------
    // registers
    //------------------------------------------------------------
    logic [1:0] rx_ctrl_ff;
    logic [3:0] tx_ctrl_ff;
    logic [7:0] ovr_ff;
    logic [1:0] int_en_ff;
    logic [1:0] int_st_ff;
    logic [1:0] mode_ff;
    logic [1:0] mgr_rdy_ff;
    logic       data_seen_ff;
    logic       flow_seen_ff;
    logic       wr;
    logic       mapped;
    logic [31:0] nxt_rdata;
    logic [1:0] int_set;
    logic [1:0] int_clr;

    assign wr = psel & penable & pwrite;

    // read mux and address decode
    always_comb
    begin
        nxt_rdata = 32'h0000_0000;
        mapped    = 1'b1;
        if (paddr == `CSLK_REG_RXC)
            nxt_rdata[1:0] = rx_ctrl_ff;
        else if (paddr == `CSLK_REG_TXC)
            nxt_rdata[3:0] = tx_ctrl_ff;
        else if (paddr == `CSLK_REG_OVR)
            nxt_rdata[7:0] = ovr_ff;
        else if (paddr == `CSLK_REG_ING)
            nxt_rdata[1:0] = mgr_rdy_ff;
        else if (paddr == `CSLK_REG_IST)
            nxt_rdata[1:0] = int_st_ff;
        else if (paddr == `CSLK_REG_ICLR)
            nxt_rdata[1:0] = 2'h0;        // write only
        else if (paddr == `CSLK_REG_IEN)
            nxt_rdata[1:0] = int_en_ff;
        else if (paddr == `CSLK_REG_MODE)
            nxt_rdata[1:0] = mode_ff;
        else
            mapped = 1'b0;
    end

    // zero wait states; read data captured in the setup cycle
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (psel && !penable)
            prdata <= nxt_rdata;
    end

    // control registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_ctrl_ff <= 2'h0;
            tx_ctrl_ff <= 4'h0;
            ovr_ff     <= `CSLK_OVR_RST;
            int_en_ff  <= 2'h0;
            mode_ff    <= 2'h0;
        end
        else if (wr)
        begin
            if (paddr == `CSLK_REG_RXC)
                rx_ctrl_ff <= pwdata[1:0];
            else if (paddr == `CSLK_REG_TXC)
                tx_ctrl_ff <= pwdata[3:0];
            else if (paddr == `CSLK_REG_OVR)
                ovr_ff <= pwdata[7:0] & `CSLK_OVR_MASK;
            else if (paddr == `CSLK_REG_IEN)
                int_en_ff <= pwdata[1:0];
            else if (paddr == `CSLK_REG_MODE)
                mode_ff <= pwdata[1:0];
        end
    end

    //------------------------------------------------------------
    // receive paths
    //------------------------------------------------------------
    logic      d_valid;
    cslk_hdr_t d_hdr;
    logic      f_valid;
    cslk_hdr_t f_hdr;
    logic      s_valid;
    cslk_hdr_t s_hdr;
    logic      d_idle;
    logic      f_idle;

    // data and flow receivers run independently of each other
    cslk_rx_det u_rx_data (
        .pclk      (pclk),
        .presetn   (presetn),
        .link_edge (link_edge),
        .enable    (rx_ctrl_ff[`CSLK_RXC_DATA]),
        .sof       (st_ff[5]),
        .dat       (st_ff[4]),
        .hdr_valid (d_valid),
        .hdr       (d_hdr)
    );

    cslk_rx_det u_rx_flow (
        .pclk      (pclk),
        .presetn   (presetn),
        .link_edge (link_edge),
        .enable    (rx_ctrl_ff[`CSLK_RXC_FLOW]),
        .sof       (st_ff[3]),
        .dat       (st_ff[2]),
        .hdr_valid (f_valid),
        .hdr       (f_hdr)
    );

    // the sideband from the partner device is always listened to
    cslk_rx_det u_rx_side (
        .pclk      (pclk),
        .presetn   (presetn),
        .link_edge (link_edge),
        .enable    (1'b1),
        .sof       (st_ff[1]),
        .dat       (st_ff[0]),
        .hdr_valid (s_valid),
        .hdr       (s_hdr)
    );

    assign d_idle = d_valid && (d_hdr[`CSLK_HDR_TYPE] == `CSLK_T_IDLE);
    assign f_idle = f_valid && (f_hdr[`CSLK_HDR_TYPE] == `CSLK_T_IDLE);

    // latched manager ready bits from the sideband
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mgr_rdy_ff <= 2'h0;
        else if (s_valid)
            mgr_rdy_ff <= s_hdr[`CSLK_HDR_RDY];
    end

    // idle seen state; forgotten when the path is disabled so a
    // restart reports the next first idle again
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            data_seen_ff <= 1'b0;
            flow_seen_ff <= 1'b0;
        end
        else
        begin
            if (!rx_ctrl_ff[`CSLK_RXC_DATA])
                data_seen_ff <= 1'b0;
            else if (d_idle)
                data_seen_ff <= 1'b1;
            if (!rx_ctrl_ff[`CSLK_RXC_FLOW])
                flow_seen_ff <= 1'b0;
            else if (f_idle)
                flow_seen_ff <= 1'b1;
        end
    end

    //------------------------------------------------------------
    // interrupts
    //------------------------------------------------------------
    assign int_set[`CSLK_INT_DIDLE] = d_idle & ~data_seen_ff;
    assign int_set[`CSLK_INT_FIDLE] = f_idle & ~flow_seen_ff;
    assign int_clr = (wr && paddr == `CSLK_REG_ICLR) ? pwdata[1:0] : 2'h0;

    // sticky status; a set in the clearing cycle wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            int_st_ff <= 2'h0;
        else
            int_st_ff <= (int_st_ff & ~int_clr) | int_set;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq <= 1'b0;
        else
            irq <= |(int_st_ff & int_en_ff);
    end

    //------------------------------------------------------------
    // transmit paths
    //------------------------------------------------------------
    logic      tx_normal;
    logic      tx_on;
    logic      alt_ff;
    logic      d_load;
    logic [1:0] d_type;
    logic [1:0] d_rdy;
    logic [1:0] s_rdy;
    logic [1:0] f_rdy;
    cslk_hdr_t d_out;
    cslk_hdr_t s_out;
    cslk_hdr_t f_out;
    logic      side_on;
    logic      flow_on;

    // normal frames need both frame enables
    assign tx_normal = tx_ctrl_ff[`CSLK_TXC_CC] &
                       tx_ctrl_ff[`CSLK_TXC_CD];
    assign tx_on = tx_ctrl_ff[`CSLK_TXC_EN] &
                   (tx_ctrl_ff[`CSLK_TXC_IDLE] | tx_normal);

    // control and data frames alternate once normal traffic runs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            alt_ff <= 1'b0;
        else if (d_load && tx_normal)
            alt_ff <= ~alt_ff;
    end

    assign d_type = !tx_normal ? `CSLK_T_IDLE :
                    (alt_ff ? `CSLK_T_DATA : `CSLK_T_CTRL);

    // forced values while overridden, else partner's ready bits
    assign d_rdy = ovr_ff[`CSLK_OVR_ING] ? ovr_ff[`CSLK_OVR_RDY]
                                         : mgr_rdy_ff;
    assign d_out = {d_type, d_rdy, `CSLK_HDR_PAD};

    // sideband reports our own receiver state unless overridden
    assign s_rdy = ovr_ff[`CSLK_OVR_EGR] ? ovr_ff[`CSLK_OVR_RDY]
                                         : {2{data_seen_ff}};
    assign s_out = {`CSLK_T_IDLE, s_rdy, `CSLK_HDR_PAD};

    // simplex ingress flow output: ready high once override released
    assign f_rdy = ovr_ff[`CSLK_OVR_EGR] ? ovr_ff[`CSLK_OVR_RDY]
                                         : `CSLK_RDY_HIGH;
    assign f_out = {`CSLK_T_IDLE, f_rdy, `CSLK_HDR_PAD};

    assign side_on = ~mode_ff[`CSLK_MODE_SPX];
    assign flow_on = mode_ff[`CSLK_MODE_SPX] & ~mode_ff[`CSLK_MODE_EGR];

    cslk_tx_ser u_tx_data (
        .pclk      (pclk),
        .presetn   (presetn),
        .link_edge (link_edge),
        .enable    (tx_on),
        .hdr       (d_out),
        .load      (d_load),
        .pins      (tx_data_pins)
    );

    cslk_tx_ser u_tx_side (
        .pclk      (pclk),
        .presetn   (presetn),
        .link_edge (link_edge),
        .enable    (side_on),
        .hdr       (s_out),
        .load      (),
        .pins      (ready_sideband_out)
    );

    cslk_tx_ser u_tx_flow (
        .pclk      (pclk),
        .presetn   (presetn),
        .link_edge (link_edge),
        .enable    (flow_on),
        .hdr       (f_out),
        .load      (),
        .pins      (tx_flow_pins)
    );
endmodule

// file: hdl/cslk_tx_ser.sv
// frame header serializer for one serial link path
`timescale 1ns/10ps
`include "cslk_map.svh"
module cslk_tx_ser
    import cslk_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       link_edge,
    input  wire logic       enable,
    input  cslk_hdr_t       hdr,
    output logic            load,
    output logic [1:0]      pins
);
    cslk_txst_t state_ff;
    cslk_hdr_t  sh_ff;
    logic [2:0] cnt_ff;

    // frames follow back to back while enabled; header is latched at start
    assign load = link_edge && enable &&
                  ((state_ff == CSLK_TX_WAIT) || (cnt_ff == `CSLK_LAST_BIT));

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff <= CSLK_TX_WAIT;
            sh_ff    <= 8'h00;
            cnt_ff   <= 3'h0;
            pins     <= 2'h0;
        end
        else if (load)
        begin
            state_ff             <= CSLK_TX_SHIFT;
            sh_ff                <= {hdr[6:0], 1'b0};
            cnt_ff               <= 3'h0;
            pins[`CSLK_PIN_SOF] <= 1'b1;
            pins[`CSLK_PIN_DAT] <= hdr[7];
        end
        else if (link_edge)
        begin
            case (state_ff)
                CSLK_TX_SHIFT:
                begin
                    if (cnt_ff == `CSLK_LAST_BIT)
                    begin
                        state_ff <= CSLK_TX_WAIT;
                        pins     <= 2'h0;
                    end
                    else
                    begin
                        cnt_ff               <= cnt_ff + 3'h1;
                        sh_ff                <= {sh_ff[6:0], 1'b0};
                        pins[`CSLK_PIN_SOF] <= 1'b0;
                        pins[`CSLK_PIN_DAT] <= sh_ff[7];
                    end
                end
                default:
                begin
                    pins <= 2'h0;
                end
            endcase
        end
    end
endmodule

// file: tb/cslk_link_peer.sv
// far-side link model: sends headers on the inbound paths and decodes the outbound ones
`timescale 1ns/10ps
module cslk_link_peer
    import cslk_pkg::*;
(
    output logic            link_clk,
    output logic [1:0]      rx_data_pins,
    output logic [1:0]      rx_flow_pins,
    output logic [1:0]      ready_sideband_in,
    input  wire logic [1:0] tx_data_pins,
    input  wire logic [1:0] tx_flow_pins,
    input  wire logic [1:0] ready_sideband_out
);
    logic [1:0] drv [3] = '{3{2'h0}};
    logic [1:0] tx [3];
    logic       busy [3] = '{3{1'b0}};
    cslk_hdr_t  got [3];
    cslk_hdr_t  sh [3];
    int         nfr [3] = '{3{0}};
    int         cnt [3] = '{3{0}};
    logic       fab_normal = 1'b0;

    // link clock runs free: the block's own transmitters are paced by it too
    initial link_clk = 1'b0;
    always #80 link_clk = ~link_clk;
    assign rx_data_pins      = drv[0];
    assign rx_flow_pins      = drv[1];
    assign ready_sideband_in = drv[2];
    assign tx[0]             = tx_data_pins;
    assign tx[1]             = tx_flow_pins;
    assign tx[2]             = ready_sideband_out;

    // ----
    // sending and decoding
    // ----
    // idle lines toggle their data bit so a stale bit never looks valid
    always @(negedge link_clk)
        for (int i = 0; i < 3; i++)
            if (!busy[i])
                drv[i][0] <= ~drv[i][0];

    // one header, msb first, changed on the falling edge
    task automatic send(input int p, input cslk_hdr_t h);
        @(posedge link_clk);
        busy[p] = 1'b1;
        for (int b = 7; b >= 0; b--)
        begin
            @(negedge link_clk);
            drv[p] = {b == 7, h[b]};
        end
        @(posedge link_clk);
        busy[p] = 1'b0;
    endtask

    // outbound headers are taken on the rising edge after the block drives
    always @(posedge link_clk)
        for (int i = 0; i < 3; i++)
            if (tx[i][1])
            begin
                sh[i] = {7'h00, tx[i][0]};
                cnt[i] = 1;
            end
            else if (cnt[i] > 0 && cnt[i] < 8)
            begin
                sh[i] = {sh[i][6:0], tx[i][0]};
                cnt[i]++;
                if (cnt[i] == 8)
                begin
                    got[i] = sh[i];
                    nfr[i]++;
                    if (i == 0 && sh[i][5:4] == 2'h3)
                        fab_normal = 1'b1;
                end
            end
endmodule

// file: tb/cslk_startup_properties.sv
// concurrent checks on the startup control block ports
`timescale 1ns/10ps
`include "cslk_map.svh"
module cslk_startup_properties
    import cslk_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pslverr,
    input wire logic [31:0] prdata,
    input wire logic        irq,
    input wire logic [1:0]  tx_data_pins,
    input wire logic [1:0]  ready_sideband_out
);
    logic [3:0] txc_ff;
    logic [1:0] ien_ff;
    wire        mapped = (paddr[1:0] == 2'b00) && (paddr <= `CSLK_REG_MODE);
    wire        acc_wr = psel && penable && pwrite;
    wire        rd_set = psel && !penable && !pwrite;
    wire        tx_go  = txc_ff[1] && (txc_ff[0] || txc_ff[3:2] == 2'b11);

    // shadow of the enables; one-cycle slack allows a pipelined enable
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            txc_ff <= 4'h0;
            ien_ff <= 2'h0;
        end
        else if (acc_wr && paddr == `CSLK_REG_TXC)
            txc_ff <= pwdata[3:0];
        else if (acc_wr && paddr == `CSLK_REG_IEN)
            ien_ff <= pwdata[1:0];
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // ----
    // properties
    // ----
    property p_slverr;
        pslverr == (psel && penable && !mapped);
    endproperty
    a_slverr: assert property (p_slverr) else $error("bad slave error");
    property p_unmap_rd;
        rd_set && !mapped |=> prdata == 32'h0;
    endproperty
    a_unmap_rd: assert property (p_unmap_rd) else $error("unmapped read not zero");
    property p_clr_rd;
        rd_set && paddr == `CSLK_REG_ICLR |=> prdata == 32'h0;
    endproperty
    a_clr_rd: assert property (p_clr_rd) else $error("clear register read not zero");
    property p_ovr_rd;
        rd_set && paddr == `CSLK_REG_OVR |=> prdata[31:8] == 24'h0 && prdata[5:2] == 4'h0;
    endproperty
    a_ovr_rd: assert property (p_ovr_rd) else $error("override spare bits set");
    property p_ist_rd;
        rd_set && paddr == `CSLK_REG_IST |=> prdata[31:2] == 30'h0;
    endproperty
    a_ist_rd: assert property (p_ist_rd) else $error("status spare bits set");
    property p_tx_start;
        $rose(tx_data_pins[`CSLK_PIN_SOF]) |-> $past(tx_go) || $past(tx_go, 2);
    endproperty
    a_tx_start: assert property (p_tx_start) else $error("frame sent while disabled");
    property p_sb_gap;
        $rose(ready_sideband_out[`CSLK_PIN_SOF]) |=> (!$rose(ready_sideband_out[`CSLK_PIN_SOF]))[*8];
    endproperty
    a_sb_gap: assert property (p_sb_gap) else $error("sideband frames too close");
    property p_irq_mask;
        $rose(irq) |-> $past(ien_ff) != 2'h0;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");
    property p_irq_off;
        acc_wr && paddr == `CSLK_REG_IEN && pwdata[1:0] == 2'h0 |-> ##2 !irq;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq stays after mask");
    property p_irq_clr;
        acc_wr && paddr == `CSLK_REG_ICLR && pwdata[1:0] == 2'h3 |-> ##2 !irq;
    endproperty
    a_irq_clr: assert property (p_irq_clr) else $error("irq stays after clear");
endmodule

bind cslk_startup cslk_startup_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
    .prdata(prdata), .irq(irq), .tx_data_pins(tx_data_pins), .ready_sideband_out(ready_sideband_out));

// file: tb/tb.sv
// self-checking bench for the cell link startup control block
`timescale 1ns/10ps
`include "cslk_map.svh"
module tb
    import cslk_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, link_clk, bus_e;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, bus_q;
    logic [1:0]  rdp, rfp, sbi, tdp, tfp, sbo;
    int          error_cnt = 0;
    int          n_checks = 0;

    always #10 pclk = ~pclk;
    cslk_startup dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata), .irq(irq),
        .link_clk(link_clk), .rx_data_pins(rdp), .rx_flow_pins(rfp), .ready_sideband_in(sbi),
        .tx_data_pins(tdp), .tx_flow_pins(tfp), .ready_sideband_out(sbo));
    cslk_link_peer peer (.link_clk(link_clk), .rx_data_pins(rdp), .rx_flow_pins(rfp),
        .ready_sideband_in(sbi), .tx_data_pins(tdp), .tx_flow_pins(tfp), .ready_sideband_out(sbo));

    // ----
    // shared tasks
    // ----
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("checks %0d, errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // one apb transfer after an idle edge; only the watchdog ends a hang
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        bus_q = prdata;
        bus_e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(bus_q, exp);
    endtask
    function automatic cslk_hdr_t hx(input logic [1:0] t, input logic [1:0] r);
        return {t, r, `CSLK_HDR_PAD};
    endfunction
    // frames run back to back, so 20 link periods always hold one fresh frame
    task automatic hdr_chk(input int p, input cslk_hdr_t exp);
        repeat (20) @(posedge link_clk);
        chk({24'h0, peer.got[p]}, {24'h0, exp});
    endtask
    task automatic wait_irq(input logic exp);
        int t = 0;
        while (irq !== exp && t < 200)
        begin
            @(posedge pclk);
            t++;
        end
        chk(32'(irq), 32'(exp));
    endtask

    // ----
    // scenarios
    // ----
    task automatic t_reset();
        rd_chk(`CSLK_REG_OVR, 32'h3);
        rd_chk(`CSLK_REG_IST, 32'h0);
        rd_chk(`CSLK_REG_ICLR, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        chk(bus_q, 32'h0);
        chk(32'(bus_e), 32'h1);
        hdr_chk(2, hx(`CSLK_T_IDLE, 2'h0));
    endtask
    task automatic t_rx_gate();
        wr(`CSLK_REG_OVR, 32'h2);
        hdr_chk(2, hx(`CSLK_T_IDLE, 2'h0));
        peer.send(0, hx(`CSLK_T_IDLE, 2'h3));
        repeat (16) @(posedge pclk);
        rd_chk(`CSLK_REG_IST, 32'h0);
        wr(`CSLK_REG_OVR, 32'h3);
    endtask
    task automatic t_bringup();
        logic [1:0] a;
        int         n;
        wr(`CSLK_REG_TXC, 32'h3);
        hdr_chk(0, hx(`CSLK_T_IDLE, 2'h0));
        wr(`CSLK_REG_RXC, 32'h1);
        wr(`CSLK_REG_OVR, 32'h1);
        peer.send(2, hx(`CSLK_T_IDLE, 2'h3));
        repeat (16) @(posedge pclk);
        rd_chk(`CSLK_REG_ING, 32'h3);
        hdr_chk(0, hx(`CSLK_T_IDLE, 2'h3));
        wr(`CSLK_REG_IEN, 32'h1);
        peer.send(0, hx(`CSLK_T_IDLE, 2'h0));
        wait_irq(1'b1);
        rd_chk(`CSLK_REG_IST, 32'h1);
        hdr_chk(2, hx(`CSLK_T_IDLE, 2'h0));
        wr(`CSLK_REG_OVR, 32'h0);
        hdr_chk(2, hx(`CSLK_T_IDLE, 2'h3));
        wr(`CSLK_REG_ICLR, 32'h1);
        wait_irq(1'b0);
        wr(`CSLK_REG_TXC, 32'h7);
        hdr_chk(0, hx(`CSLK_T_IDLE, 2'h3));
        wr(`CSLK_REG_TXC, 32'hF);
        repeat (20) @(posedge link_clk);
        a = peer.got[0][7:6];
        n = peer.nfr[0];
        wait (peer.nfr[0] != n);
        chk(32'(a ^ peer.got[0][7:6]), 32'h3);
        chk(32'(a == `CSLK_T_CTRL || a == `CSLK_T_DATA), 32'h1);
        chk(32'(peer.got[0][5:4]), 32'h3);
    endtask
    task automatic t_override();
        wr(`CSLK_REG_OVR, 32'h43);
        hdr_chk(2, hx(`CSLK_T_IDLE, 2'h1));
        chk(32'(peer.got[0][5:4]), 32'h1);
        wr(`CSLK_REG_OVR, 32'hFF);
        rd_chk(`CSLK_REG_OVR, 32'hC3);
        hdr_chk(2, hx(`CSLK_T_IDLE, 2'h3));
        chk(32'(peer.fab_normal), 32'h1);
    endtask
    task automatic t_simplex();
        wr(`CSLK_REG_TXC, 32'h0);
        wr(`CSLK_REG_MODE, 32'h2);
        wr(`CSLK_REG_OVR, 32'h3);
        hdr_chk(1, hx(`CSLK_T_IDLE, 2'h0));
        wr(`CSLK_REG_OVR, 32'h2);
        hdr_chk(1, hx(`CSLK_T_IDLE, 2'h3));
        wr(`CSLK_REG_MODE, 32'h3);
        wr(`CSLK_REG_ICLR, 32'h3);
        wr(`CSLK_REG_RXC, 32'h2);
        wr(`CSLK_REG_IEN, 32'h2);
        peer.send(0, hx(`CSLK_T_IDLE, 2'h0));
        peer.send(1, hx(`CSLK_T_IDLE, 2'h0));
        wait_irq(1'b1);
        rd_chk(`CSLK_REG_IST, 32'h2);
        wr(`CSLK_REG_IEN, 32'h0);
        wait_irq(1'b0);
        wr(`CSLK_REG_ICLR, 32'h2);
        rd_chk(`CSLK_REG_IST, 32'h0);
    endtask

    // watchdog: the scenarios need well under 100 us
    initial
    begin
        #400us;
        error_cnt++;
        test_done();
    end

    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
        t_reset();
        t_rx_gate();
        t_bringup();
        t_override();
        t_simplex();
        test_done();
    end
endmodule
